// *** common/cps_pkg.sv ***
`default_nettype none
package cps_pkg;
    // ******************************
    // register map and fields
    // ******************************
    localparam logic [9:0]  CPS_CTRL_OFFSET    = 10'h000;
    localparam logic [15:0] CPS_CTRL_RESET     = 16'h0000;
    localparam int          CPS_MODE_LSB       = 0;
    localparam int          CPS_SLEEP_LSB      = 2;
    localparam int          CPS_STAGES_LSB     = 4;
    localparam int          CPS_DECIM_LSB      = 8;
    localparam int          CPS_SOFT_RST_BIT   = 10;
    localparam int          CPS_IRQ_POL_BIT    = 11;
    localparam int          CPS_EXCITE_OFF_BIT = 12;
    localparam int          CPS_UNUSED_BIT     = 13;
    localparam int          CPS_BIAS_LSB       = 14;
    // bits that store a value; soft reset and the unused bit read zero
    localparam logic [15:0] CPS_CTRL_KEEP_MASK = 16'hdbff;
    localparam logic [3:0]  CPS_STAGES_MAX     = 4'hc;
    localparam logic [8:0]  CPS_DECIM_256      = 9'h100;
    localparam logic [8:0]  CPS_DECIM_128      = 9'h080;
    localparam logic [8:0]  CPS_DECIM_64       = 9'h040;

    // ******************************
    // timing
    // ******************************
    localparam int unsigned CPS_CLK_HZ         = 25_000_000;
    localparam int unsigned CPS_FULL_PERIOD_MS = 36;
    localparam int unsigned CPS_SLEEP_STEP_MS  = 200;
    localparam int unsigned CPS_FULL_PERIOD_CYC = CPS_FULL_PERIOD_MS * (CPS_CLK_HZ / 1000);
    localparam int unsigned CPS_SLEEP_STEP_CYC  = CPS_SLEEP_STEP_MS * (CPS_CLK_HZ / 1000);
    localparam int          CPS_TIMER_W        = 25;

    // ******************************
    // types
    // ******************************
    typedef enum logic [1:0] {
        CPS_MODE_FULL   = 2'b00,
        CPS_MODE_SHUT_A = 2'b01,
        CPS_MODE_LOW    = 2'b10,
        CPS_MODE_SHUT_B = 2'b11
    } cps_mode_t;

    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [9:0]  addr;
        logic [15:0] wdata;
    } cps_reg_req_t;

    typedef struct packed {
        logic [15:0]            ctrl;
        logic [CPS_TIMER_W-1:0] timer;
        logic                   seq_start;
        logic                   soft_rst;
        logic                   irq_pin;
        logic [15:0]            rdata;
        logic                   rd_valid;
        logic [3:0]             stages;
        logic [8:0]             decim;
        logic                   excite_en;
        logic [1:0]             bias;
        logic                   low_power;
        logic                   shutdown;
    } cps_state_t;
endpackage
`default_nettype wire

// *** hw/cps_power_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module cps_power_ctrl #(
    parameter int unsigned P_FULL_PERIOD_CYC = cps_pkg::CPS_FULL_PERIOD_CYC,
    parameter int unsigned P_SLEEP_STEP_CYC  = cps_pkg::CPS_SLEEP_STEP_CYC
) (
    // clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_n_in,
    // register access from the serial interface
    input  wire cps_pkg::cps_reg_req_t reg_req_in,
    output var  logic [15:0]          reg_rdata_out,
    output var  logic                 reg_rd_valid_out,
    // interrupt
    input  wire logic                 irq_event_in,
    output var  logic                 irq_pin_out,
    // converter controls
    output var  logic                 seq_start_out,
    output var  logic                 low_power_out,
    output var  logic                 shutdown_out,
    output var  logic [3:0]           stage_count_out,
    output var  logic [8:0]           decim_ratio_out,
    output var  logic                 excite_en_out,
    output var  logic [1:0]           bias_boost_out,
    output var  logic                 soft_reset_pulse_out
);
    import cps_pkg::*;

    cps_state_t st_r;
    cps_state_t st_nxt;
    cps_mode_t  mode_nxt;
    logic       ctrl_wr;
    logic [CPS_TIMER_W-1:0] period;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        st_nxt = st_r;
        ctrl_wr = reg_req_in.wr_en && (reg_req_in.addr == CPS_CTRL_OFFSET);
        st_nxt.soft_rst = 1'b0;
        if (ctrl_wr) begin
            if (reg_req_in.wdata[CPS_SOFT_RST_BIT]) begin
                st_nxt.ctrl = CPS_CTRL_RESET;
                st_nxt.soft_rst = 1'b1;
            end else begin
                // bit 13 is not stored, so a stray one never reads back
                st_nxt.ctrl = reg_req_in.wdata & CPS_CTRL_KEEP_MASK;
            end
        end
        mode_nxt = cps_mode_t'(st_nxt.ctrl[CPS_MODE_LSB +: 2]);
        period = '0;
        st_nxt.low_power = 1'b0;
        st_nxt.shutdown = 1'b0;
        case (mode_nxt)
            CPS_MODE_FULL: begin
                period = CPS_TIMER_W'(P_FULL_PERIOD_CYC - 1);
            end
            CPS_MODE_LOW: begin
                st_nxt.low_power = 1'b1;
                period = CPS_TIMER_W'(P_SLEEP_STEP_CYC
                         * (st_nxt.ctrl[CPS_SLEEP_LSB +: 2] + 32'd1) - 1);
            end
            CPS_MODE_SHUT_A, CPS_MODE_SHUT_B: begin
                st_nxt.shutdown = 1'b1;
            end
            default: begin
                st_nxt.shutdown = 1'b1;
            end
        endcase
        // a write restarts the interval so a new rate takes effect at once
        st_nxt.seq_start = 1'b0;
        if (ctrl_wr || st_nxt.shutdown) begin
            st_nxt.timer = period;
        end else if (st_r.timer == '0) begin
            st_nxt.timer = period;
            st_nxt.seq_start = 1'b1;
        end else begin
            st_nxt.timer = st_r.timer - 1'b1;
        end
        if (st_nxt.ctrl[CPS_STAGES_LSB +: 4] >= (CPS_STAGES_MAX - 4'h1)) begin
            st_nxt.stages = CPS_STAGES_MAX;
        end else begin
            st_nxt.stages = st_nxt.ctrl[CPS_STAGES_LSB +: 4] + 4'h1;
        end
        case (st_nxt.ctrl[CPS_DECIM_LSB +: 2])
            2'b00:   st_nxt.decim = CPS_DECIM_256;
            2'b01:   st_nxt.decim = CPS_DECIM_128;
            default: st_nxt.decim = CPS_DECIM_64;
        endcase
        st_nxt.excite_en = ~st_nxt.ctrl[CPS_EXCITE_OFF_BIT];
        st_nxt.bias = st_nxt.ctrl[CPS_BIAS_LSB +: 2];
        // stored polarity is used, so a polarity write moves the pin one cycle later
        st_nxt.irq_pin = st_r.ctrl[CPS_IRQ_POL_BIT] ? irq_event_in : ~irq_event_in;
        // read returns the stored value; unmapped offsets read zero
        st_nxt.rd_valid = reg_req_in.rd_en;
        st_nxt.rdata = '0;
        if (reg_req_in.rd_en && reg_req_in.addr == CPS_CTRL_OFFSET) begin
            st_nxt.rdata = st_r.ctrl;
        end
    end

    // ******************************
    // state register
    // ******************************
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // outputs in reset already show the decode of an all-zero register
            st_r <= '0;
            st_r.ctrl <= CPS_CTRL_RESET;
            st_r.stages <= 4'h1;
            st_r.decim <= CPS_DECIM_256;
            st_r.excite_en <= 1'b1;
            st_r.irq_pin <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.rdata;
    assign reg_rd_valid_out = st_r.rd_valid;
    assign irq_pin_out = st_r.irq_pin;
    assign seq_start_out = st_r.seq_start;
    assign low_power_out = st_r.low_power;
    assign shutdown_out = st_r.shutdown;
    assign stage_count_out = st_r.stages;
    assign decim_ratio_out = st_r.decim;
    assign excite_en_out = st_r.excite_en;
    assign bias_boost_out = st_r.bias;
    assign soft_reset_pulse_out = st_r.soft_rst;

    // ******************************
    // checks
    // ******************************
    a_full_power_period: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (seq_start_out && st_r.ctrl[1:0] == 2'b00)
        |-> st_r.timer == CPS_TIMER_W'(P_FULL_PERIOD_CYC - 1))
        else $error("full power interval reload wrong");
    a_shutdown_no_start: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (st_r.ctrl[0] == 1'b1) |-> (!seq_start_out && shutdown_out && !low_power_out))
        else $error("conversion started in shutdown");
    a_sleep_interval: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (seq_start_out && st_r.ctrl[1:0] == 2'b10)
        |-> st_r.timer == CPS_TIMER_W'(P_SLEEP_STEP_CYC * (st_r.ctrl[3:2] + 32'd1) - 1))
        else $error("low power interval reload wrong");
    a_stage_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (st_r.ctrl[7:4] <= 4'hb) |-> stage_count_out == st_r.ctrl[7:4] + 4'h1)
        else $error("stage count does not match field");
    a_decim_ratio: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        decim_ratio_out == (st_r.ctrl[9] ? CPS_DECIM_64
                           : (st_r.ctrl[8] ? CPS_DECIM_128 : CPS_DECIM_256)))
        else $error("decimation ratio wrong");
    a_soft_reset_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_req_in.wr_en && reg_req_in.addr == CPS_CTRL_OFFSET
         && reg_req_in.wdata[CPS_SOFT_RST_BIT])
        |=> (st_r.ctrl == CPS_CTRL_RESET && soft_reset_pulse_out)
        ##1 (!soft_reset_pulse_out
             || $past(reg_req_in.wr_en && reg_req_in.addr == CPS_CTRL_OFFSET
                      && reg_req_in.wdata[CPS_SOFT_RST_BIT])))
        else $error("soft reset did not clear register");
    a_irq_polarity: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ##1 irq_pin_out == ($past(irq_event_in) ~^ $past(st_r.ctrl[11])))
        else $error("interrupt pin level wrong");
    a_excite_enable: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        excite_en_out == !st_r.ctrl[12])
        else $error("excitation enable wrong");
    a_bias_select: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        bias_boost_out == st_r.ctrl[15:14])
        else $error("bias select wrong");
    a_unstored_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (st_r.ctrl[13] == 1'b0 && st_r.ctrl[10] == 1'b0))
        else $error("unused or self-clearing bit stored");

    // ******************************
    // register port, mode and stage clamp checks
    // ******************************
    a_read_answer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_req_in.rd_en && reg_req_in.addr == CPS_CTRL_OFFSET)
        |=> (reg_rd_valid_out && reg_rdata_out == $past(st_r.ctrl)))
        else $error("read did not return stored value");
    a_read_unmapped: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_req_in.rd_en && reg_req_in.addr != CPS_CTRL_OFFSET)
        |=> (reg_rd_valid_out && reg_rdata_out == 16'h0000))
        else $error("unmapped read not zero");
    a_read_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !reg_req_in.rd_en
        |=> (!reg_rd_valid_out && reg_rdata_out == 16'h0000))
        else $error("read data without a read");
    a_write_store: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_req_in.wr_en && reg_req_in.addr == CPS_CTRL_OFFSET
         && !reg_req_in.wdata[CPS_SOFT_RST_BIT])
        |=> st_r.ctrl == $past(reg_req_in.wdata & CPS_CTRL_KEEP_MASK))
        else $error("write not stored");
    a_write_restart: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_req_in.wr_en && reg_req_in.addr == CPS_CTRL_OFFSET)
        |=> !seq_start_out)
        else $error("sequence started on a write");
    a_low_power_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        low_power_out == (st_r.ctrl[1:0] == 2'b10))
        else $error("low power level wrong");
    a_full_power_on: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (st_r.ctrl[0] == 1'b0)
        |-> !shutdown_out)
        else $error("shutdown outside shutdown modes");
    a_stage_clamp: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (st_r.ctrl[7:4] > 4'hb)
        |-> stage_count_out == CPS_STAGES_MAX)
        else $error("stage count not clamped");
    a_soft_pulse_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        soft_reset_pulse_out
        |-> $past(reg_req_in.wr_en && reg_req_in.addr == CPS_CTRL_OFFSET
                  && reg_req_in.wdata[CPS_SOFT_RST_BIT]))
        else $error("soft reset pulse without request");
endmodule
`default_nettype wire

// *** verif/cps_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cps_pkg::*;
    localparam int FULL_CYC = 20;
    localparam int STEP_CYC = 30;
    typedef struct packed {
        logic [15:0] wdata;
        logic        ev;
        logic [18:0] exp;
    } cps_row_t;
    logic         clk_sys_in;
    logic         rst_n_in;
    cps_reg_req_t req;
    logic         irq_event;
    logic [15:0]  rdata;
    logic         rd_valid, irq_pin, seq_start, low_power, shutdown, excite_en, soft_pulse;
    logic [3:0]   stage_count;
    logic [8:0]   decim;
    logic [1:0]   bias;
    logic [18:0]  obs;
    int           mismatches;
    int           n_checks;
    int           n;
    cps_row_t     rows [6];

    cps_power_ctrl #(.P_FULL_PERIOD_CYC(FULL_CYC), .P_SLEEP_STEP_CYC(STEP_CYC)) cps_power_ctrl_inst (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .reg_rd_valid_out(rd_valid), .irq_event_in(irq_event),
        .irq_pin_out(irq_pin), .seq_start_out(seq_start), .low_power_out(low_power),
        .shutdown_out(shutdown), .stage_count_out(stage_count), .decim_ratio_out(decim),
        .excite_en_out(excite_en), .bias_boost_out(bias), .soft_reset_pulse_out(soft_pulse));

    assign obs = {stage_count, decim, excite_en, bias, low_power, shutdown, irq_pin};

    // ******************************
    // helpers
    // ******************************
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // an idle edge first, so back-to-back calls never retoggle a strobe in one step
    task automatic wr(input logic [9:0] addr, input logic [15:0] data);
        @(posedge clk_sys_in); #5;
        req = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys_in); #5;
        req = '0;
    endtask

    task automatic rd(input logic [9:0] addr, input logic [15:0] exp);
        @(posedge clk_sys_in); #5;
        req = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: 16'h0000};
        @(posedge clk_sys_in); #5;
        req = '0;
        chk({3'h0, rd_valid, rdata}, {4'h1, exp});
    endtask

    // cycles to the next sequence start; bounded
    task automatic gap(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_sys_in); #5;
            cnt++;
        end while (seq_start !== 1'b1 && cnt < 300);
        if (cnt >= 300) begin
            mismatches++;
            end_sim();
        end
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        #400_000;
        mismatches++;
        end_sim();
    end

    // ******************************
    // main sequence
    // ******************************
    initial begin
        // expected: stages, decimation, excite, bias, low power, shutdown, irq pin
        rows[0] = '{16'h0000, 1'b1, {4'h1, 9'h100, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0}};
        rows[1] = '{16'h4106, 1'b0, {4'h1, 9'h080, 1'b1, 2'h1, 1'b1, 1'b0, 1'b1}};
        rows[2] = '{16'h9bb1, 1'b1, {4'hc, 9'h040, 1'b0, 2'h2, 1'b0, 1'b1, 1'b1}};
        rows[3] = '{16'hd2f3, 1'b0, {4'hc, 9'h040, 1'b0, 2'h3, 1'b0, 1'b1, 1'b1}};
        rows[4] = '{16'h0012, 1'b1, {4'h2, 9'h100, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0}};
        rows[5] = '{16'h0800, 1'b0, {4'h1, 9'h100, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0}};
        mismatches = 0;
        n_checks = 0;
        rst_n_in = 1'b0;
        req = '0;
        irq_event = 1'b0;
        repeat (10) @(posedge clk_sys_in);
        #5;
        chk({1'b0, obs}, {1'b0, 4'h1, 9'h100, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1});
        chk({19'h0, soft_pulse}, 20'h0);
        chk({18'h0, seq_start, rd_valid}, 20'h0);
        rst_n_in = 1'b1;
        rd(10'h000, CPS_CTRL_RESET);
        foreach (rows[i]) begin
            irq_event = rows[i].ev;
            wr(CPS_CTRL_OFFSET, rows[i].wdata);
            @(posedge clk_sys_in); #5;
            chk({1'b0, obs}, {1'b0, rows[i].exp});
            rd(CPS_CTRL_OFFSET, rows[i].wdata & CPS_CTRL_KEEP_MASK);
        end
        // unmapped place: write ignored, read gives zero
        wr(10'h001, 16'hffff);
        rd(10'h000, 16'h0800);
        rd(10'h001, 16'h0000);
        // sequencer spacing, second gap avoids the reload after the write
        wr(10'h000, 16'h0000);
        gap(n);
        gap(n);
        chk(20'(n), 20'(FULL_CYC));
        wr(10'h000, 16'h0006);
        gap(n);
        gap(n);
        chk(20'(n), 20'(2 * STEP_CYC));
        wr(10'h000, 16'h000e);
        gap(n);
        gap(n);
        chk(20'(n), 20'(4 * STEP_CYC));
        wr(10'h000, 16'h0002);
        gap(n);
        gap(n);
        chk(20'(n), 20'(STEP_CYC));
        wr(10'h000, 16'h000a);
        gap(n);
        gap(n);
        chk(20'(n), 20'(3 * STEP_CYC));
        wr(10'h000, 16'h0003);
        repeat (150) begin
            @(posedge clk_sys_in); #5;
            chk({19'h0, seq_start}, 20'h0);
        end
        // soft reset clears everything and the trigger does not stick
        wr(10'h000, 16'h9bb1);
        wr(10'h000, 16'h0400);
        chk({19'h0, soft_pulse}, 20'h1);
        chk({2'h0, obs[18:1]}, {2'h0, 4'h1, 9'h100, 1'b1, 2'h0, 1'b0, 1'b0});
        @(posedge clk_sys_in); #5;
        chk({19'h0, soft_pulse}, 20'h0);
        chk({19'h0, irq_pin}, 20'h1);
        rd(10'h000, 16'h0000);
        // reset in mid-run brings back the power-on state
        wr(10'h000, 16'h9bb1);
        rst_n_in = 1'b0;
        @(posedge clk_sys_in);
        #5;
        chk({1'b0, obs}, {1'b0, 4'h1, 9'h100, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1});
        chk({18'h0, seq_start, soft_pulse}, 20'h0);
        rst_n_in = 1'b1;
        @(posedge clk_sys_in);
        #5;
        chk({19'h0, seq_start}, 20'h1);
        rd(10'h000, CPS_CTRL_RESET);
        end_sim();
    end
endmodule
`default_nettype wire
